// file: logic/intprio_pkg.sv
package intprio_pkg;

	// ------------------------------------------------------------
	// Sources and priority codes
	// ------------------------------------------------------------
	localparam int         NUM_SOURCES   = 6;
	localparam int         PRIO_W        = 3;
	localparam logic [2:0] PRIO_DISABLED = 3'h0;
	localparam logic [2:0] PRIO_LOWEST   = 3'h1;
	localparam logic [2:0] PRIO_HIGHEST  = 3'h7;
	localparam logic [2:0] PRIO_RESET    = 3'h4;

	// Source index order used by the request and arbitration outputs
	localparam logic [2:0] SRC_FAULT_A = 3'h0;
	localparam logic [2:0] SRC_DMA5    = 3'h1;
	localparam logic [2:0] SRC_AUDIO   = 3'h2;
	localparam logic [2:0] SRC_UART2   = 3'h3;
	localparam logic [2:0] SRC_UART1   = 3'h4;
	localparam logic [2:0] SRC_FAULT_B = 3'h5;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] OFFS_PRIO_A = 16'h0000;
	localparam logic [15:0] OFFS_PRIO_B = 16'h0004;

	localparam int FAULT_A_LSB = 12;
	localparam int DMA5_LSB    = 4;
	localparam int AUDIO_LSB   = 0;
	localparam int UART2_LSB   = 8;
	localparam int UART1_LSB   = 4;
	localparam int FAULT_B_LSB = 0;

	localparam logic [15:0] MASK_PRIO_A  = 16'h7077;
	localparam logic [15:0] MASK_PRIO_B  = 16'h0777;
	localparam logic [15:0] RESET_PRIO_A = 16'h4044;
	localparam logic [15:0] RESET_PRIO_B = 16'h0444;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] pwm_fault_a_priority;
		logic [2:0] dma_ch5_done_priority;
		logic [2:0] audio_serial_event_priority;
		logic [2:0] uart2_error_priority;
		logic [2:0] uart1_error_priority;
		logic [2:0] pwm_fault_b_priority;
	} prio_fields_t;

	localparam prio_fields_t PRIO_FIELDS_RESET = '{default: PRIO_RESET};

	typedef struct packed {
		logic       valid;
		logic [2:0] level;
		logic [2:0] source;
	} top_request_t;

endpackage

// file: logic/interrupt_priority_fields.sv
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Field code 111 means level 7, the highest level a source can hold.
// - Field code 001 means level 1, lowest active; codes between map linearly to 2..6.
// - Field code 000 disables the source; it never raises a request.
// - DMA channel 5 done priority sits in bits 6..4 of the first register.
// - UART1 error priority sits in bits 6..4 of the second register.
module interrupt_priority_fields #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]           s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Interrupt sources and arbitration side
	input  wire logic [5:0]                  src_flag,
	output intprio_pkg::prio_fields_t        prio,
	output logic [5:0]                       src_req,
	output intprio_pkg::top_request_t        top
);

	if (ADDR_W < 3 || ADDR_W > 16) begin
		$error("ADDR_W must lie between 3 and 16");
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] offs);
		addr_hit = ({addr[ADDR_W-1:2], 2'b00} == offs[ADDR_W-1:0]);
	endfunction

	function automatic logic [15:0] pack_a(input intprio_pkg::prio_fields_t f);
		logic [15:0] r;
		r = 16'h0000;
		r[intprio_pkg::FAULT_A_LSB +: 3] = f.pwm_fault_a_priority;
		r[intprio_pkg::DMA5_LSB +: 3]    = f.dma_ch5_done_priority;
		r[intprio_pkg::AUDIO_LSB +: 3]   = f.audio_serial_event_priority;
		pack_a = r;
	endfunction

	function automatic logic [15:0] pack_b(input intprio_pkg::prio_fields_t f);
		logic [15:0] r;
		r = 16'h0000;
		r[intprio_pkg::UART2_LSB +: 3]   = f.uart2_error_priority;
		r[intprio_pkg::UART1_LSB +: 3]   = f.uart1_error_priority;
		r[intprio_pkg::FAULT_B_LSB +: 3] = f.pwm_fault_b_priority;
		pack_b = r;
	endfunction

	// Byte-lane merge; bits outside the mask always come out zero
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
			input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		merge = r & mask;
	endfunction

	function automatic logic [2:0] prio_of(input intprio_pkg::prio_fields_t f, input logic [2:0] idx);
		case (idx)
			intprio_pkg::SRC_FAULT_A: prio_of = f.pwm_fault_a_priority;
			intprio_pkg::SRC_DMA5:    prio_of = f.dma_ch5_done_priority;
			intprio_pkg::SRC_AUDIO:   prio_of = f.audio_serial_event_priority;
			intprio_pkg::SRC_UART2:   prio_of = f.uart2_error_priority;
			intprio_pkg::SRC_UART1:   prio_of = f.uart1_error_priority;
			intprio_pkg::SRC_FAULT_B: prio_of = f.pwm_fault_b_priority;
			default:                  prio_of = intprio_pkg::PRIO_DISABLED;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Write channel and priority fields
	// ------------------------------------------------------------
	logic                       aw_got;
	logic                       w_got;
	logic [ADDR_W-1:0]          aw_addr;
	logic [31:0]                w_data;
	logic [3:0]                 w_strb;
	logic                       next_aw_got;
	logic                       next_w_got;
	logic [ADDR_W-1:0]          next_aw_addr;
	logic [31:0]                next_w_data;
	logic [3:0]                 next_w_strb;
	logic                       next_awready;
	logic                       next_wready;
	logic                       next_bvalid;
	logic [1:0]                 next_bresp;
	intprio_pkg::prio_fields_t  next_prio;

	always_comb begin
		logic [15:0] reg_val;
		reg_val      = 16'h0000;
		next_aw_got  = aw_got;
		next_w_got   = w_got;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_awready = s_axi_awready;
		next_wready  = s_axi_wready;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_prio    = prio;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_got  = 1'b1;
			next_aw_addr = s_axi_awaddr;
			next_awready = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_got  = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
			next_wready = 1'b0;
		end
		if (aw_got && w_got && !s_axi_bvalid) begin
			next_aw_got = 1'b0;
			next_w_got  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = intprio_pkg::RESP_OKAY;
			if (addr_hit(aw_addr, intprio_pkg::OFFS_PRIO_A)) begin
				reg_val = merge(pack_a(prio), w_data, w_strb, intprio_pkg::MASK_PRIO_A);
				next_prio.pwm_fault_a_priority        = reg_val[intprio_pkg::FAULT_A_LSB +: 3];
				next_prio.dma_ch5_done_priority       = reg_val[intprio_pkg::DMA5_LSB +: 3];
				next_prio.audio_serial_event_priority = reg_val[intprio_pkg::AUDIO_LSB +: 3];
			end else if (addr_hit(aw_addr, intprio_pkg::OFFS_PRIO_B)) begin
				reg_val = merge(pack_b(prio), w_data, w_strb, intprio_pkg::MASK_PRIO_B);
				next_prio.uart2_error_priority = reg_val[intprio_pkg::UART2_LSB +: 3];
				next_prio.uart1_error_priority = reg_val[intprio_pkg::UART1_LSB +: 3];
				next_prio.pwm_fault_b_priority = reg_val[intprio_pkg::FAULT_B_LSB +: 3];
			end else begin
				next_bresp = intprio_pkg::RESP_SLVERR;
			end
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid  = 1'b0;
			next_awready = 1'b1;
			next_wready  = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= '0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= intprio_pkg::RESP_OKAY;
			prio          <= intprio_pkg::PRIO_FIELDS_RESET;
		end else begin
			aw_got        <= next_aw_got;
			w_got         <= next_w_got;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			prio          <= next_prio;
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	logic        next_arready;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;

	always_comb begin
		next_arready = s_axi_arready;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = intprio_pkg::RESP_OKAY;
			if (addr_hit(s_axi_araddr, intprio_pkg::OFFS_PRIO_A)) begin
				next_rdata = {16'h0000, pack_a(prio)};
			end else if (addr_hit(s_axi_araddr, intprio_pkg::OFFS_PRIO_B)) begin
				next_rdata = {16'h0000, pack_b(prio)};
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = intprio_pkg::RESP_SLVERR;
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= intprio_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// ------------------------------------------------------------
	// Request gating and highest-level pick
	// ------------------------------------------------------------
	logic [5:0]                 enabled;
	logic [5:0]                 at_top;
	logic [5:0]                 at_lowest;
	logic [5:0]                 next_src_req;
	intprio_pkg::top_request_t  next_top;

	// Ties go to the lower source index
	always_comb begin
		logic [2:0] lvl;
		lvl          = intprio_pkg::PRIO_DISABLED;
		enabled      = 6'h00;
		at_top       = 6'h00;
		at_lowest    = 6'h00;
		next_src_req = 6'h00;
		next_top     = '0;
		for (int i = 0; i < intprio_pkg::NUM_SOURCES; i++) begin
			lvl          = prio_of(prio, 3'(i));
			enabled[i]   = (lvl != intprio_pkg::PRIO_DISABLED);
			at_top[i]    = (lvl == intprio_pkg::PRIO_HIGHEST);
			at_lowest[i] = (lvl == intprio_pkg::PRIO_LOWEST);
			next_src_req[i] = src_flag[i] && enabled[i];
			if (next_src_req[i] && (lvl > next_top.level)) begin
				next_top.valid  = 1'b1;
				next_top.level  = lvl;
				next_top.source = 3'(i);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_req <= 6'h00;
			top     <= '0;
		end else begin
			src_req <= next_src_req;
			top     <= next_top;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence read_a_taken;
		s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, intprio_pkg::OFFS_PRIO_A);
	endsequence

	sequence read_b_taken;
		s_axi_arvalid && s_axi_arready && addr_hit(s_axi_araddr, intprio_pkg::OFFS_PRIO_B);
	endsequence

	chk_highest_level_wins: assert property (
		(|(src_flag & at_top)) |=> (top.valid && top.level == intprio_pkg::PRIO_HIGHEST))
		else $error("level 7 request not chosen as top");

	chk_lowest_level_only: assert property (
		(top.valid && top.level == intprio_pkg::PRIO_LOWEST)
			|-> ($past(src_flag & enabled & ~at_lowest) == 6'h00 && $past(|(src_flag & at_lowest))))
		else $error("level 1 chosen while a higher request stood");

	chk_level_matches_source: assert property (
		top.valid |-> (top.level == prio_of($past(prio), top.source) && src_req[top.source]))
		else $error("top level does not match its source field");

	chk_disabled_silent: assert property (
		(src_req & ~$past(enabled)) == 6'h00)
		else $error("disabled source raised a request");

	chk_enabled_requests: assert property (
		(|(src_flag & enabled)) |=> (top.valid && src_req != 6'h00))
		else $error("enabled flagged source gave no request");

	chk_dma5_field_bits: assert property (
		read_a_taken ##1 1'b1 |-> (s_axi_rvalid && s_axi_rdata[6:4] == $past(prio.dma_ch5_done_priority)))
		else $error("DMA5 priority not read at bits 6..4");

	chk_uart1_field_bits: assert property (
		read_b_taken ##1 1'b1 |-> (s_axi_rvalid && s_axi_rdata[6:4] == $past(prio.uart1_error_priority)))
		else $error("UART1 error priority not read at bits 6..4");

	chk_reset_fields: assert property (
		$past(!aresetn) |-> (prio == intprio_pkg::PRIO_FIELDS_RESET && !s_axi_bvalid && !s_axi_rvalid))
		else $error("fields not at reset value after reset");

	chk_reserved_zero: assert property (
		s_axi_rvalid |-> ((s_axi_rdata & ~{16'h0000, intprio_pkg::MASK_PRIO_A | intprio_pkg::MASK_PRIO_B})
			== 32'h0000_0000))
		else $error("reserved bits read non-zero");

	chk_write_answer: assert property (
		(aw_got && w_got && !s_axi_bvalid) |=> s_axi_bvalid ##0 (!s_axi_awready && !s_axi_wready))
		else $error("write response missing one cycle after address and data");

endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                      aclk;
	logic                      aresetn;
	logic                      awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]                awaddr, araddr;
	logic [31:0]               wdata;
	logic [3:0]                wstrb;
	logic [5:0]                flags;
	wire logic                 awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]           bresp, rresp;
	wire logic [31:0]          rdata;
	wire logic [5:0]           src_req;
	intprio_pkg::prio_fields_t prio;
	intprio_pkg::top_request_t top;
	logic [15:0]               exp_a, exp_b;
	int                        n_mismatch, n_compared, cycles, seed, i;

	interrupt_priority_fields dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.src_flag(flags), .prio(prio), .src_req(src_req), .top(top)
	);

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// ------------------------------------------------------------
	// Reporting and comparison
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop();
		end
	end

	task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cmp_top(input intprio_pkg::top_request_t g, input intprio_pkg::top_request_t e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: top got %h expected %h", $time, g, e);
		end
	endtask

	// ------------------------------------------------------------
	// Expectations
	// ------------------------------------------------------------
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s,
		input logic [15:0] m);
		logic [15:0] v;
		v = old;
		if (s[0]) v[7:0] = d[7:0];
		if (s[1]) v[15:8] = d[15:8];
		return v & m;
	endfunction

	function automatic intprio_pkg::prio_fields_t fields(input logic [15:0] a, input logic [15:0] b);
		return {a[14:12], a[6:4], a[2:0], b[10:8], b[6:4], b[2:0]};
	endfunction

	function automatic logic [5:0] exp_req(input intprio_pkg::prio_fields_t f, input logic [5:0] fl);
		logic [5:0] r;
		for (int j = 0; j < 6; j++) r[j] = fl[j] && (f[17-3*j -: 3] != 3'h0);
		return r;
	endfunction

	function automatic intprio_pkg::top_request_t exp_top(input intprio_pkg::prio_fields_t f, input logic [5:0] fl);
		intprio_pkg::top_request_t t;
		t = '0;
		for (int j = 0; j < 6; j++) begin
			if (fl[j] && f[17-3*j -: 3] > t.level) begin
				t.valid = 1'b1;
				t.level = f[17-3*j -: 3];
				t.source = j[2:0];
			end
		end
		return t;
	endfunction

	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	task automatic do_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] r;
		logic [1:0] er;
		er = intprio_pkg::RESP_OKAY;
		if (a == 8'h00) exp_a = merge(exp_a, d, s, 16'h7077);
		else if (a == 8'h04) exp_b = merge(exp_b, d, s, 16'h0777);
		else er = intprio_pkg::RESP_SLVERR;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		r = 2'bxx;
		for (int k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				break;
			end
		end
		cmp_val({30'h0, r}, {30'h0, er});
	endtask

	task automatic do_read(input logic [7:0] a);
		logic [31:0] d;
		logic [31:0] ed;
		logic [1:0] r;
		ed = (a == 8'h00) ? {16'h0, exp_a} : (a == 8'h04) ? {16'h0, exp_b} : 32'h0000_0000;
		araddr <= a;
		arvalid <= 1'b1;
		d = 'x;
		r = 2'bxx;
		for (int k = 0; k < 50; k++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		cmp_val(d, ed);
		cmp_val({30'h0, r}, (a == 8'h00 || a == 8'h04) ? 32'h0000_0000 : 32'h0000_0002);
	endtask

	task automatic check_all;
		intprio_pkg::prio_fields_t ef;
		ef = fields(exp_a, exp_b);
		repeat (2) @(posedge aclk);
		cmp_val({14'h0, prio}, {14'h0, ef});
		cmp_val({26'h0, src_req}, {26'h0, exp_req(ef, flags)});
		cmp_top(top, exp_top(ef, flags));
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 32'hd56c;
		n_mismatch = 0;
		n_compared = 0;
		{awvalid, wvalid, arvalid} = 3'h0;
		{bready, rready} = 2'h3;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		flags = 6'h00;
		aresetn = 1'b0;
		exp_a = 16'h4044;
		exp_b = 16'h0444;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		flags <= 6'h3f;
		do_read(8'h00);
		do_read(8'h04);
		check_all();
		$display("test reset values done");
		do_write(8'h00, 32'hffff_ffff, 4'hf);
		do_write(8'h04, 32'hffff_ffff, 4'hf);
		do_read(8'h00);
		do_read(8'h04);
		check_all();
		$display("test unimplemented bits done");
		do_write(8'h00, 32'h0000_1071, 4'h3);
		do_write(8'h04, 32'h0000_0710, 4'h3);
		check_all();
		do_write(8'h00, 32'h0000_0000, 4'h3);
		do_write(8'h04, 32'h0000_0000, 4'h3);
		check_all();
		$display("test tie and disable done");
		for (i = 0; i < 8; i++) begin
			do_write(8'h00, {16'h0, 1'b0, i[2:0], 5'h0, i[2:0], 1'b0, i[2:0]}, 4'h3);
			flags <= 6'h07;
			check_all();
		end
		$display("test every code done");
		do_write(8'h08, 32'hffff_ffff, 4'hf);
		do_write(8'hfc, 32'hffff_ffff, 4'hf);
		do_read(8'h08);
		do_write(8'h00, 32'h0000_00ff, 4'h2);
		do_read(8'h00);
		$display("test unmapped and strobes done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		exp_a = intprio_pkg::RESET_PRIO_A;
		exp_b = intprio_pkg::RESET_PRIO_B;
		@(posedge aclk);
		do_read(8'h00);
		do_read(8'h04);
		check_all();
		$display("test mid-run reset done");
		for (i = 0; i < 40; i++) begin
			do_write(8'(({$random(seed)} % 3) * 4), $random(seed), 4'($random(seed)));
			flags <= 6'($random(seed));
			do_read(8'(({$random(seed)} % 3) * 4));
			check_all();
		end
		$display("test random traffic done");
		report_and_stop();
	end

endmodule
